/* rtl/mda_divider.sv */
// mda_divider: restoring serial divider, one quotient bit per clock
// assumes a non-zero divisor; the caller handles division by zero
`timescale 1ns/1ps
module mda_divider #(
  parameter int unsigned N_W = 32,
  parameter int unsigned D_W = 16
) (
  // clock and reset
  input  wire logic           i_sys_clk,
  input  wire logic           i_reset_n,
  // request
  input  wire logic           i_start,
  input  wire logic [N_W-1:0] i_dividend,
  input  wire logic [D_W-1:0] i_divisor,
  // result
  output logic                o_done,
  output logic [N_W-1:0]      o_quotient,
  output logic [D_W-1:0]      o_remainder
);

  localparam int unsigned CW = $clog2(N_W + 1);

  logic [D_W-1:0] divisor;
  logic [CW-1:0]  bits_left;
  logic           busy;
  logic [D_W:0]   shifted;
  logic [D_W:0]   trial;

  always_comb begin
    shifted = {o_remainder, o_quotient[N_W-1]};
    trial   = shifted - {1'b0, divisor};
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      divisor     <= '0;
      bits_left   <= '0;
      busy        <= 1'b0;
      o_done      <= 1'b0;
      o_quotient  <= '0;
      o_remainder <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        divisor     <= i_divisor;
        o_quotient  <= i_dividend;
        o_remainder <= '0;
        bits_left   <= CW'(N_W);
        busy        <= 1'b1;
      end else if (busy) begin
        if (shifted >= {1'b0, divisor}) begin
          o_remainder <= trial[D_W-1:0];
          o_quotient  <= {o_quotient[N_W-2:0], 1'b1};
        end else begin
          o_remainder <= shifted[D_W-1:0];
          o_quotient  <= {o_quotient[N_W-2:0], 1'b0};
        end
        bits_left <= bits_left - CW'(1);
        if (bits_left == CW'(1)) begin
          busy   <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

endmodule : mda_divider

/* rtl/mda_pkg.sv */
// mda_pkg: constants, register map and types of the multiply/divide/accumulate unit
// assumes one 50 MHz core clock and an APB slave port with 32-bit data
package mda_pkg;

  localparam int unsigned  RAM_WORDS   = 128;
  localparam logic [11:0]  OFS_CMD     = 12'h000;
  localparam logic [11:0]  OFS_STATUS  = 12'h004;
  localparam logic [11:0]  OFS_FLAGS   = 12'h008;
  localparam logic [11:0]  OFS_ACC     = 12'h00c;
  localparam logic [11:0]  OFS_LOW     = 12'h010;
  localparam logic [11:0]  OFS_BYTE    = 12'h014;
  localparam logic [11:0]  OFS_PAIR    = 12'h018;
  localparam logic [11:0]  OFS_PTRA    = 12'h01c;
  localparam logic [11:0]  OFS_PTRB    = 12'h020;
  localparam logic [11:0]  OFS_SPTR    = 12'h024;
  localparam logic [11:0]  OFS_COUNT   = 12'h028;
  localparam logic [2:0]   RAM_SEL     = 3'h2;
  localparam int unsigned  CMD_CNT_LSB = 8;
  localparam int unsigned  STAT_BUSY   = 0;
  localparam int unsigned  STAT_YIELD  = 1;
  localparam int unsigned  STAT_BLOCK  = 2;
  localparam logic [15:0]  PTR_STEP    = 16'h0002;
  localparam logic [31:0]  MAC_MAX     = 32'h7fffffff;
  localparam logic [31:0]  MAC_MIN     = 32'h80000000;
  localparam logic [31:0]  DIV_ONES    = 32'hffffffff;
  localparam logic [15:0]  RST_WORD    = 16'h0000;
  localparam logic [7:0]   RST_BYTE    = 8'h00;

  typedef struct packed {
    logic s;
    logic z;
    logic half_carry;
    logic pv;
    logic carry;
  } mda_flags_t;

  localparam mda_flags_t   RST_FLAGS   = '0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mda_apb_req_t;

  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_CMP   = 4'h1,
    OP_UBMUL = 4'h2,
    OP_WDIV  = 4'h3,
    OP_UWMUL = 4'h4,
    OP_LDIV  = 4'h5,
    OP_SWMUL = 4'h6,
    OP_MAC   = 4'h7,
    OP_MACS  = 4'h8,
    OP_SAC   = 4'h9
  } mda_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DIV  = 2'b11
  } mda_state_t;

endpackage : mda_pkg

/* rtl/mda_unit.sv */
// mda_unit: compare flags, multiply, divide and repeated accumulate engine with operand window
// assumes APB master on the core clock and a same-clock interrupt pending level from the core
`timescale 1ns/1ps
module mda_unit #(
  parameter int unsigned WORDS = mda_pkg::RAM_WORDS
) (
  // clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset_n,
  // apb slave
  input  wire mda_pkg::mda_apb_req_t i_apb,
  output logic [31:0]               o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // core side
  input  wire logic                 i_irq_req,
  output mda_pkg::mda_flags_t       o_flags,
  output logic                      o_busy,
  output logic                      o_irq_block,
  output logic                      o_yield
);
  import mda_pkg::*;

  logic [15:0] acc_word;
  logic [15:0] low_acc_word;
  logic [7:0]  byte_reg;
  logic [15:0] pair_reg;
  logic [15:0] ptr_a;
  logic [15:0] ptr_b;
  logic [15:0] sample_pointer;
  logic [7:0]  count_reg;
  logic [7:0]  run_count;
  logic        yielded;
  mda_op_t     op;
  mda_state_t  state;
  mda_state_t  next_state;
  logic [15:0] ram [WORDS];

  // bus decode
  logic        acc_first;
  logic        acc_commit;
  logic        wr_commit;
  logic        ram_hit;
  logic [6:0]  ram_idx;
  logic [31:0] rd_data;
  logic        rd_err;
  logic        cmd_go;
  mda_op_t     cmd_op;
  logic [7:0]  cmd_cnt;

  assign acc_first  = i_apb.psel & i_apb.penable & ~o_pready;
  assign acc_commit = i_apb.psel & i_apb.penable & o_pready;
  assign wr_commit  = acc_commit & i_apb.pwrite & ~o_pslverr;
  assign ram_hit    = (i_apb.paddr[11:9] == RAM_SEL);
  assign ram_idx    = i_apb.paddr[8:2];
  assign cmd_op     = mda_op_t'(i_apb.pwdata[3:0]);
  assign cmd_cnt    = i_apb.pwdata[CMD_CNT_LSB +: 8];
  assign cmd_go     = wr_commit & (i_apb.paddr == OFS_CMD);

  always_comb begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    if (ram_hit) begin
      rd_data = {16'h0000, ram[ram_idx]};
    end else begin
      case (i_apb.paddr)
        OFS_CMD:    rd_data = {16'h0000, run_count, 4'h0, op};
        OFS_STATUS: rd_data = {29'h0, o_irq_block, yielded, o_busy};
        OFS_FLAGS:  rd_data = {27'h0, o_flags};
        OFS_ACC:    rd_data = {16'h0000, acc_word};
        OFS_LOW:    rd_data = {16'h0000, low_acc_word};
        OFS_BYTE:   rd_data = {24'h000000, byte_reg};
        OFS_PAIR:   rd_data = {16'h0000, pair_reg};
        OFS_PTRA:   rd_data = {16'h0000, ptr_a};
        OFS_PTRB:   rd_data = {16'h0000, ptr_b};
        OFS_SPTR:   rd_data = {16'h0000, sample_pointer};
        OFS_COUNT:  rd_data = {24'h000000, count_reg};
        default:    rd_err  = 1'b1;
      endcase
    end
    if (i_apb.paddr[1:0] != 2'b00) begin
      rd_err = 1'b1;
    end
    if (i_apb.pwrite && (o_busy || i_apb.paddr == OFS_STATUS)) begin
      rd_err = 1'b1;
    end
  end

  // one wait state: answer in the second access cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready <= acc_first;
      if (acc_first) begin
        o_pslverr <= rd_err;
        o_prdata  <= i_apb.pwrite ? 32'h00000000 : rd_data;
      end else begin
        o_pslverr <= 1'b0;
        o_prdata  <= 32'h00000000;
      end
    end
  end

  // word compare
  logic [16:0] cmp_diff;
  mda_flags_t  cmp_flags;

  always_comb begin
    cmp_diff     = {1'b0, acc_word} - {1'b0, pair_reg};
    cmp_flags.s  = cmp_diff[15];
    cmp_flags.z  = (cmp_diff[15:0] == 16'h0000);
    cmp_flags.half_carry = 1'b0;
    cmp_flags.pv = (acc_word[15] ^ pair_reg[15]) & (cmp_diff[15] ^ acc_word[15]);
    cmp_flags.carry = cmp_diff[16];
  end

  // one-shot multiplies
  logic [15:0] ubyte_prod;
  logic [31:0] uword_prod;
  logic [31:0] sword_prod;

  always_comb begin
    ubyte_prod = 16'(acc_word[7:0] * byte_reg);
    uword_prod = 32'(acc_word * pair_reg);
    sword_prod = 32'($signed(acc_word) * $signed(pair_reg));
  end

  // multiply-accumulate step, operands from the fixed window
  logic [15:0] mac_x;
  logic [15:0] mac_y;
  logic [31:0] mac_prod;
  logic [32:0] mac_sum;
  logic        mac_ovf;
  logic [31:0] mac_result;

  always_comb begin
    mac_x      = ram[ptr_a[7:1]];
    mac_y      = ram[ptr_b[7:1]];
    mac_prod   = 32'($signed(mac_x) * $signed(mac_y));
    mac_sum    = {acc_word[15], acc_word, low_acc_word} + {mac_prod[31], mac_prod};
    mac_ovf    = mac_sum[32] ^ mac_sum[31];
    mac_result = mac_sum[31:0];
    if (mac_ovf && op == OP_MACS) begin
      mac_result = mac_sum[32] ? MAC_MIN : MAC_MAX;
    end
  end

  // correlation step
  logic [15:0] sac_x;
  logic [15:0] sac_y;
  logic [15:0] sac_abs;
  logic [16:0] sac_sum;
  logic        sac_end;

  always_comb begin
    sac_x   = ram[low_acc_word[7:1]];
    sac_y   = ram[sample_pointer[7:1]];
    sac_abs = (sac_x >= sac_y) ? (sac_x - sac_y) : (sac_y - sac_x);
    sac_sum = {1'b0, acc_word} + {1'b0, sac_abs};
    sac_end = sac_sum[16] | (count_reg == 8'h01);
  end

  // divider shared by both divides
  logic        div_start;
  logic        div_done;
  logic [31:0] div_quot;
  logic [15:0] div_rem;
  logic [31:0] div_num;
  logic [15:0] div_den;

  assign div_num = (cmd_op == OP_LDIV) ? {acc_word, low_acc_word} : {16'h0000, acc_word};
  assign div_den = (cmd_op == OP_LDIV) ? pair_reg : {8'h00, byte_reg};

  mda_divider #(
    .N_W (32),
    .D_W (16)
  ) u_divider (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_start     (div_start),
    .i_dividend  (div_num),
    .i_divisor   (div_den),
    .o_done      (div_done),
    .o_quotient  (div_quot),
    .o_remainder (div_rem)
  );

  assign div_start = cmd_go & (next_state == ST_DIV);

  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_go) begin
          case (cmd_op)
            OP_WDIV: if (byte_reg != 8'h00) next_state = ST_DIV;
            OP_LDIV: if (pair_reg != 16'h0000) next_state = ST_DIV;
            OP_MAC, OP_MACS: if (cmd_cnt != 8'h00) next_state = ST_RUN;
            OP_SAC: if (count_reg != 8'h00) next_state = ST_RUN;
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_RUN: begin
        if (op == OP_SAC) begin
          if (i_irq_req || sac_end) next_state = ST_IDLE;
        end else if (mac_ovf || run_count == 8'h01) begin
          next_state = ST_IDLE;
        end
      end
      ST_DIV: begin
        if (div_done) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state       <= ST_IDLE;
      o_busy      <= 1'b0;
      o_irq_block <= 1'b0;
    end else begin
      state       <= next_state;
      o_busy      <= (next_state != ST_IDLE);
      o_irq_block <= (next_state == ST_RUN) && (cmd_go ? cmd_op != OP_SAC : op != OP_SAC);
    end
  end

  // operand window: software writes, engine only reads
  always_ff @(posedge i_sys_clk) begin
    if (wr_commit && ram_hit) begin
      ram[ram_idx] <= i_apb.pwdata[15:0];
    end
  end

  // working registers and flags
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_word       <= RST_WORD;
      low_acc_word   <= RST_WORD;
      byte_reg       <= RST_BYTE;
      pair_reg       <= RST_WORD;
      ptr_a          <= RST_WORD;
      ptr_b          <= RST_WORD;
      sample_pointer <= RST_WORD;
      count_reg      <= RST_BYTE;
      run_count      <= RST_BYTE;
      yielded        <= 1'b0;
      op             <= OP_NONE;
      o_flags        <= RST_FLAGS;
      o_yield        <= 1'b0;
    end else begin
      o_yield <= 1'b0;
      if (wr_commit && !ram_hit) begin
        case (i_apb.paddr)
          OFS_FLAGS: o_flags <= i_apb.pwdata[4:0];
          OFS_ACC:   acc_word <= i_apb.pwdata[15:0];
          OFS_LOW:   low_acc_word <= i_apb.pwdata[15:0];
          OFS_BYTE:  byte_reg <= i_apb.pwdata[7:0];
          OFS_PAIR:  pair_reg <= i_apb.pwdata[15:0];
          OFS_PTRA:  ptr_a <= i_apb.pwdata[15:0];
          OFS_PTRB:  ptr_b <= i_apb.pwdata[15:0];
          OFS_SPTR:  sample_pointer <= i_apb.pwdata[15:0];
          OFS_COUNT: count_reg <= i_apb.pwdata[7:0];
          OFS_CMD: begin
            op        <= cmd_op;
            run_count <= cmd_cnt;
            yielded   <= 1'b0;
            case (cmd_op)
              OP_CMP: o_flags <= cmp_flags;
              OP_UBMUL: acc_word <= ubyte_prod;
              OP_UWMUL: begin
                acc_word <= uword_prod[31:16];
                pair_reg <= uword_prod[15:0];
              end
              OP_SWMUL: begin
                acc_word <= sword_prod[31:16];
                pair_reg <= sword_prod[15:0];
              end
              OP_WDIV: begin
                if (byte_reg == 8'h00) begin
                  acc_word <= DIV_ONES[15:0];
                  byte_reg <= acc_word[7:0];
                end
              end
              OP_LDIV: begin
                if (pair_reg == 16'h0000) begin
                  acc_word     <= DIV_ONES[31:16];
                  low_acc_word <= DIV_ONES[15:0];
                  pair_reg     <= low_acc_word;
                end
              end
              default: yielded <= 1'b0;
            endcase
          end
          default: yielded <= yielded;
        endcase
      end
      case (state)
        ST_DIV: begin
          if (div_done) begin
            if (op == OP_LDIV) begin
              acc_word     <= div_quot[31:16];
              low_acc_word <= div_quot[15:0];
              pair_reg     <= div_rem;
            end else begin
              acc_word <= div_quot[15:0];
              byte_reg <= div_rem[7:0];
            end
          end
        end
        ST_RUN: begin
          if (op == OP_SAC) begin
            if (i_irq_req) begin
              yielded <= 1'b1;
              o_yield <= 1'b1;
            end else begin
              acc_word  <= sac_sum[15:0];
              o_flags.carry <= sac_sum[16];
              if (!sac_sum[16]) begin
                low_acc_word   <= low_acc_word + PTR_STEP;
                sample_pointer <= sample_pointer + PTR_STEP;
                count_reg      <= count_reg - 8'h01;
              end
            end
          end else begin
            {acc_word, low_acc_word} <= mac_result;
            o_flags.pv <= mac_ovf;
            if (!mac_ovf) begin
              ptr_a     <= ptr_a + PTR_STEP;
              ptr_b     <= ptr_b + PTR_STEP;
              run_count <= run_count - 8'h01;
            end
          end
        end
        default: yielded <= yielded;
      endcase
    end
  end

endmodule : mda_unit

/* test/mda_core_irq_model.sv */
// mda_core_irq_model: core-side pending interrupt level seen by the unit
// assumes one core clock; the core takes the request whenever the unit lets it
`timescale 1ns/1ps
module mda_core_irq_model (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset_n,
  // request and unit state
  input  wire logic i_raise,
  input  wire logic i_busy,
  input  wire logic i_irq_block,
  input  wire logic i_yield,
  output logic      o_irq_req
);
  // pending until the unit yields or stands idle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) o_irq_req <= 1'b0;
    else if (i_raise) o_irq_req <= 1'b1;
    else if (i_yield || !(i_busy || i_irq_block)) o_irq_req <= 1'b0;
  end
endmodule : mda_core_irq_model

/* test/mda_unit_properties.sv */
// mda_unit_properties: port-level checks of the accumulate and yield behaviour
// assumes the top module ports of mda_unit; attached by bind
`timescale 1ns/1ps
module mda_unit_properties #(
  parameter int unsigned WORDS = mda_pkg::RAM_WORDS
) (
  input wire logic                  i_sys_clk,
  input wire logic                  i_reset_n,
  input wire mda_pkg::mda_apb_req_t i_apb,
  input wire logic                  o_pready,
  input wire logic                  i_irq_req,
  input wire mda_pkg::mda_flags_t   o_flags,
  input wire logic                  o_busy,
  input wire logic                  o_irq_block,
  input wire logic                  o_yield
);
  import mda_pkg::*;
  logic wcommit;
  assign wcommit = i_apb.psel & i_apb.penable & i_apb.pwrite & o_pready;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  blk_busy_a: assert property (o_irq_block |-> o_busy)
    else $error("irq block without busy");
  blk_no_yield_a: assert property (o_irq_block |-> !o_yield)
    else $error("yield during accumulate");
  blk_cause_a: assert property ($rose(o_irq_block) |-> $past(wcommit))
    else $error("irq block without command");
  blk_bound_a: assert property ($rose(o_irq_block) |-> ##[1:257] !o_irq_block)
    else $error("accumulate runs too long");
  yield_cause_a: assert property (o_yield |-> $past(i_irq_req))
    else $error("yield without pending request");
  yield_pulse_a: assert property (o_yield |=> !o_yield)
    else $error("yield longer than one cycle");
  yield_stop_a: assert property (o_yield |=> !o_busy)
    else $error("busy after yield");
  flags_hold_a: assert property (!o_busy && !wcommit |=> $stable(o_flags))
    else $error("flags moved while idle");
endmodule : mda_unit_properties
bind mda_unit mda_unit_properties #(.WORDS(WORDS)) u_props (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
  .i_apb(i_apb), .o_pready(o_pready), .i_irq_req(i_irq_req), .o_flags(o_flags), .o_busy(o_busy),
  .o_irq_block(o_irq_block), .o_yield(o_yield));

/* test/mda_unit_tb.sv */
// mda_unit_tb: self-checking bench driving the unit over apb
// assumes the register map and op codes of mda_pkg
`timescale 1ns/1ps
module mda_unit_tb;
  import mda_pkg::*;
  logic         clk, rst_n, irq_raise, irq_req, pready, pslverr, busy, irq_block, yield, e, irq_on;
  mda_apb_req_t apb_r;
  mda_flags_t   flags;
  logic [31:0]  prdata, q, x;
  logic [15:0]  a, b, ea, el, ep;
  logic [7:0]   eb;
  logic [4:0]   fl;
  logic [3:0]   op;
  int           errors, compares, seed, s;
  mda_unit #(.WORDS(RAM_WORDS)) u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_apb(apb_r), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_irq_req(irq_req), .o_flags(flags), .o_busy(busy),
    .o_irq_block(irq_block), .o_yield(yield));
  mda_core_irq_model u_core (.i_sys_clk(clk), .i_reset_n(rst_n), .i_raise(irq_raise), .i_busy(busy),
    .i_irq_block(irq_block), .i_yield(yield), .o_irq_req(irq_req));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    apb_r <= '{1'b1, 1'b0, w, ad, d};
    @(posedge clk);
    apb_r.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_r <= '0;
  endtask : apb
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask : wr
  task automatic rc(input string nm, input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(nm, q, exp);
  endtask : rc
  task automatic run(input logic [31:0] cmd);
    wr(OFS_CMD, cmd);
    irq_raise <= irq_on;
    @(posedge clk);
    irq_raise <= 1'b0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
    end while (q[STAT_BUSY] !== 1'b0);
  endtask : run
  function automatic logic [11:0] wa(input logic [7:0] p);
    return 12'h400 + {3'h0, p[7:1], 2'h0};
  endfunction : wa
  function automatic logic [4:0] cmp_f(input logic [15:0] p, input logic [15:0] r);
    logic [16:0] d;
    d = {1'b0, p} - {1'b0, r};
    return {d[15], d[15:0] == 16'h0000, 1'b0, (p[15] ^ r[15]) & (p[15] ^ d[15]), d[16]};
  endfunction : cmp_f
  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    seed = 16;
    errors = 0;
    compares = 0;
    rst_n = 1'b0;
    irq_raise = 1'b0;
    irq_on = 1'b1;
    apb_r = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc("flags reset", OFS_FLAGS, 32'h0);
    apb(1'b0, 12'h02c, 32'h0);
    chk("unmapped", 32'(e), 32'h1);
    wr(OFS_STATUS, 32'h1);
    chk("status write", 32'(e), 32'h1);
    apb(1'b0, 12'h00d, 32'h0);
    chk("misaligned", 32'(e), 32'h1);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'h8000 : (i == 1) ? 16'h1234 : (i == 2) ? 16'h0000 : 16'($random(seed));
      b = (i == 0) ? 16'h0001 : (i == 1) ? 16'h1234 : (i == 2) ? 16'h0001 : 16'($random(seed));
      wr(OFS_ACC, 32'(a));
      wr(OFS_PAIR, 32'(b));
      run({28'h0, OP_CMP});
      rc("cmp flags", OFS_FLAGS, 32'(cmp_f(a, b)));
      rc("cmp acc", OFS_ACC, 32'(a));
      chk("flags port", 32'(flags), 32'(cmp_f(a, b)));
    end
    for (int i = 0; i < 10; i++) begin
      op = 4'h2 + 4'(i % 5);
      a = 16'($random(seed));
      b = (i >= 5) ? 16'h0000 : 16'($random(seed));
      x = $random(seed);
      fl = 5'(x[31:27]);
      wr(OFS_FLAGS, 32'(fl));
      wr(OFS_ACC, 32'(a));
      wr(OFS_LOW, 32'(x[15:0]));
      wr(OFS_BYTE, 32'(b[7:0]));
      wr(OFS_PAIR, 32'(b));
      run({28'h0, op});
      ea = a;
      el = x[15:0];
      eb = b[7:0];
      ep = b;
      case (op)
        4'h2: ea = a[7:0] * b[7:0];
        4'h3: begin
          ea = (b[7:0] == 8'h00) ? 16'hffff : a / b[7:0];
          eb = (b[7:0] == 8'h00) ? a[7:0] : 8'(a % b[7:0]);
        end
        4'h4: {ea, ep} = a * b;
        4'h5: begin
          {ea, el} = (b == 16'h0000) ? 32'hffffffff : {a, x[15:0]} / b;
          ep = (b == 16'h0000) ? x[15:0] : 16'({a, x[15:0]} % b);
        end
        default: {ea, ep} = $signed(a) * $signed(b);
      endcase
      rc("acc", OFS_ACC, 32'(ea));
      rc("low", OFS_LOW, 32'(el));
      rc("byte", OFS_BYTE, 32'(eb));
      rc("pair", OFS_PAIR, 32'(ep));
      rc("flags kept", OFS_FLAGS, 32'(fl));
    end
    wr(OFS_ACC, 32'h0);
    wr(OFS_LOW, 32'h64);
    wr(OFS_PAIR, 32'h7);
    wr(OFS_CMD, {28'h0, OP_LDIV});
    wr(OFS_ACC, 32'h1234);
    chk("busy write", 32'(e), 32'h1);
    repeat (40) @(posedge clk);
    rc("busy div acc", OFS_ACC, 32'h0);
    rc("busy div low", OFS_LOW, 32'he);
    rc("busy div pair", OFS_PAIR, 32'h2);
    s = $random(seed) & 32'h00ffffff;
    wr(OFS_ACC, 32'(s[31:16]));
    wr(OFS_LOW, 32'(s[15:0]));
    for (int i = 0; i < 3; i++) begin
      x = $random(seed);
      a = {{4{x[11]}}, x[11:0]};
      b = {{4{x[27]}}, x[27:16]};
      wr(wa(8'h10 + 8'(2 * i)), 32'(a));
      wr(wa(8'h40 + 8'(2 * i)), 32'(b));
      s = s + $signed(a) * $signed(b);
    end
    wr(OFS_PTRA, 32'h10);
    wr(OFS_PTRB, 32'h40);
    wr(OFS_FLAGS, 32'h0);
    run({16'h0, 8'd3, 4'h0, OP_MAC});
    rc("mac acc", OFS_ACC, 32'(s[31:16]));
    rc("mac low", OFS_LOW, 32'(s[15:0]));
    rc("mac ptra", OFS_PTRA, 32'h16);
    rc("mac ptrb", OFS_PTRB, 32'h46);
    rc("mac flags", OFS_FLAGS, 32'h0);
    for (int j = 0; j < 3; j++) begin
      wr(OFS_ACC, (j == 1) ? 32'h8001 : 32'h7fff);
      wr(OFS_LOW, 32'h0);
      wr(wa(8'h20), 32'h4000);
      wr(wa(8'h50), (j == 1) ? 32'hc000 : 32'h4000);
      wr(OFS_PTRA, 32'h20);
      wr(OFS_PTRB, 32'h50);
      wr(OFS_FLAGS, 32'h0);
      run({16'h0, 8'd2, 4'h0, (j == 2) ? OP_MAC : OP_MACS});
      if (j < 2) begin
        rc("sat acc", OFS_ACC, (j == 1) ? 32'h8000 : 32'h7fff);
        rc("sat low", OFS_LOW, (j == 1) ? 32'h0000 : 32'hffff);
      end
      rc("ovf ptra", OFS_PTRA, 32'h20);
      rc("ovf ptrb", OFS_PTRB, 32'h50);
      rc("ovf flags", OFS_FLAGS, 32'h2);
    end
    s = $random(seed) & 32'h0fff;
    wr(OFS_ACC, 32'(s));
    for (int i = 0; i < 4; i++) begin
      x = $random(seed) & 32'h0fff0fff;
      wr(wa(8'h60 + 8'(2 * i)), 32'(x[15:0]));
      wr(wa(8'h80 + 8'(2 * i)), 32'(x[31:16]));
      s = s + ((x[15:0] > x[31:16]) ? x[15:0] - x[31:16] : x[31:16] - x[15:0]);
    end
    wr(OFS_LOW, 32'h60);
    wr(OFS_SPTR, 32'h80);
    wr(OFS_COUNT, 32'h4);
    wr(OFS_FLAGS, 32'h0);
    run({28'h0, OP_SAC});
    rc("yield status", OFS_STATUS, 32'h2);
    rc("yield count", OFS_COUNT, 32'h3);
    irq_on = 1'b0;
    run({28'h0, OP_SAC});
    rc("sac acc", OFS_ACC, 32'(s[15:0]));
    rc("sac low", OFS_LOW, 32'h68);
    rc("sac sptr", OFS_SPTR, 32'h88);
    rc("sac count", OFS_COUNT, 32'h0);
    rc("sac flags", OFS_FLAGS, 32'h0);
    wr(OFS_ACC, 32'hfff0);
    wr(wa(8'h60), 32'h0100);
    wr(wa(8'h80), 32'h0000);
    wr(OFS_LOW, 32'h60);
    wr(OFS_SPTR, 32'h80);
    wr(OFS_COUNT, 32'h2);
    wr(OFS_CMD, {28'h0, OP_SAC});
    repeat (4) @(posedge clk);
    rc("carry acc", OFS_ACC, 32'h00f0);
    rc("carry low", OFS_LOW, 32'h60);
    rc("carry sptr", OFS_SPTR, 32'h80);
    rc("carry flags", OFS_FLAGS, 32'h1);
    print_verdict();
  end
endmodule : mda_unit_tb
